// [inc/dps_pkg.sv]
/*
  Shared constants and port structs for the discharge pulse sequencer.
  Assumes a single 10 MHz core clock and switch inputs already debounced
  and synchronous to that clock.
*/
package dps_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DWELL_MIN_MS = 333;
  localparam int unsigned DWELL_MAX_MS = 20_000;
  localparam int unsigned DWELL_MIN_CYC = (CLK_HZ / 1000) * DWELL_MIN_MS;
  localparam int unsigned DWELL_MAX_CYC = (CLK_HZ / 1000) * DWELL_MAX_MS;
  localparam int unsigned DWELL_STEP_CYC = (DWELL_MAX_CYC - DWELL_MIN_CYC) / 255;
  localparam int unsigned PULSE_NS = 10_000_000;
  localparam int unsigned PULSE_CYC_DEF = PULSE_NS / 100;
  localparam int unsigned BLINK_NS = 50_000_000;
  localparam int unsigned BLINK_CYC_DEF = BLINK_NS / 100;
  localparam int unsigned CNT_W = 28;
  // ==========================================================
  // Selector and counter values
  // ==========================================================
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_MAX = 4'h9;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 28'h000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 28'h000_0001;

  // Three-state panel trigger
  typedef enum logic [1:0] {
    DPS_PANEL_OFF,
    DPS_PANEL_AUTO,
    DPS_PANEL_MANUAL
  } dps_panel_t;

  // Operator switch bundle
  typedef struct packed {
    logic arm;
    logic gun_hv_switch;
    logic gun_trigger;
    logic gun_auto;
    logic air_gap_mode;
    logic free_run;
    logic [3:0] count_sel;
    logic [7:0] interval_sel;
  } dps_sw_t;

  // Lamp bundle
  typedef struct packed {
    logic armed_lamp;
    logic hv_lamp;
    logic charge_lamp;
    logic discharge_lamp;
    logic green_lamp;
  } dps_lamp_t;
endpackage

// [verilog/dps_sequencer.sv]
/*
  Discharge pulse sequencer: turns trigger switches into timed relay pulses,
  drives the pulse readout and the status lamps.
  Assumes debounced synchronous switches; relay driver is active high.
*/
// Behaviour
// - Counted mode fires exactly the selected 1..9 pulses, dwell apart.
// - Trigger release or auto off clears the counter and stops pulses.
// - Dwell is settable from one third second to about twenty seconds.
// - Selector at zero inhibits every relay-mode pulse; air mode still holds the relay.
// - Ten selector positions; position one gives single shot.
// - Continuous mode ignores selector count except zero, pulses while trigger runs.
// - Readout blanked in continuous mode, lit in counted mode.
// - Single digit readout shows pulses produced this sequence.
// - Each new trigger activation restarts the sequence.
// - Arm switch gates high voltage; amber lamp while armed.
// - Relay mode closes the relay briefly for each pulse.
// - Air mode holds relay closed while trigger is held.
// - Panel trigger parallels gun: off, auto, momentary manual.
// - Green lamp blinks once per discharge pulse.
// - Gun button starts sequence, runs while held, resets on release.
// - Gun selector picks air or relay discharge mode.
// - Discharge needs gun HV switch and arm; yellow lamp shows HV.
// - Charge lamp when armed and idle; discharge lamp during pulse.
module dps_sequencer
  import dps_pkg::*;
#(
  parameter int unsigned PULSE_CYC = PULSE_CYC_DEF,
  parameter int unsigned BLINK_CYC = BLINK_CYC_DEF,
  parameter int unsigned DWELL_BASE = DWELL_MIN_CYC,
  parameter int unsigned DWELL_STEP = DWELL_STEP_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire dps_sw_t i_sw,
  input wire dps_panel_t i_panel,
  output logic o_relay,
  output logic [3:0] o_readout,
  output logic o_readout_on,
  output dps_lamp_t o_lamp
);

  typedef enum logic [1:0] {
    DPS_IDLE,
    DPS_DWELL,
    DPS_PULSE,
    DPS_DONE
  } dps_state_t;

  // ==========================================================
  // Decode
  // ==========================================================
  // Dwell length for a selector code; linear between the two limits
  function automatic logic [CNT_W-1:0] dwell_len(input logic [7:0] sel);
    dwell_len = CNT_W'(DWELL_BASE + DWELL_STEP * sel);
  endfunction

  logic run;
  logic enabled;
  logic run_d_r;
  logic start;
  logic relay_mode;
  logic [CNT_W-1:0] dwell_now;
  logic go;

  // Any of the three trigger sources runs the sequence
  assign run = i_sw.gun_trigger || i_sw.gun_auto || (i_panel != DPS_PANEL_OFF);
  // Both interlocks and a non-zero count are needed; zero inhibits even free run
  assign enabled = i_sw.arm && i_sw.gun_hv_switch && (i_sw.count_sel != COUNT_ZERO);
  assign start = run && !run_d_r;
  assign relay_mode = !i_sw.air_gap_mode;
  assign dwell_now = dwell_len(i_sw.interval_sel);
  // Everything a relay-mode sequence needs, decoded once for all users
  assign go = run && enabled && relay_mode;

  // Edge memory of the combined trigger
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= run;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  dps_state_t state_r;
  dps_state_t state_nxt;
  logic [CNT_W-1:0] tmr_r;
  logic [3:0] count_r;
  logic last_pulse;

  // True on the cycle a phase is entered, so its timer is loaded only once
  function automatic logic entering(input dps_state_t cur, input dps_state_t nxt, input dps_state_t ph);
    entering = (nxt == ph) && (cur != ph);
  endfunction

  assign last_pulse = !i_sw.free_run && (count_r + COUNT_ONE >= i_sw.count_sel);

  // Next state; losing run or interlock always drops back to idle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DPS_IDLE: begin
        if (go) begin
          state_nxt = DPS_DWELL;
        end
      end
      DPS_DWELL: begin
        if (tmr_r == CNT_ZERO) begin
          state_nxt = DPS_PULSE;
        end
      end
      DPS_PULSE: begin
        if (tmr_r == CNT_ZERO) begin
          state_nxt = last_pulse ? DPS_DONE : DPS_DWELL;
        end
      end
      DPS_DONE: begin
        state_nxt = DPS_DONE;
      end
    endcase
    if (!go || start) begin
      state_nxt = go ? DPS_DWELL : DPS_IDLE;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= DPS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase timer: loaded on each phase entry, counts down to zero
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tmr_r <= CNT_ZERO;
    end else if (entering(state_r, state_nxt, DPS_DWELL)) begin
      tmr_r <= dwell_now - CNT_ONE;
    end else if (entering(state_r, state_nxt, DPS_PULSE)) begin
      tmr_r <= CNT_W'(PULSE_CYC - 1);
    end else if (tmr_r != CNT_ZERO) begin
      tmr_r <= tmr_r - CNT_ONE;
    end
  end

  // Pulse count: cleared on release or restart, saturates at nine
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count_r <= COUNT_ZERO;
    end else if (!run || start) begin
      count_r <= COUNT_ZERO;
    end else if (state_r == DPS_PULSE && state_nxt != DPS_PULSE && count_r != COUNT_MAX) begin
      count_r <= count_r + COUNT_ONE;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  logic relay_nxt;
  logic [CNT_W-1:0] blink_r;

  // Relay pulses per step in relay mode, follows the held trigger in air mode
  assign relay_nxt = (state_nxt == DPS_PULSE)
                  || (i_sw.air_gap_mode && run && i_sw.arm && i_sw.gun_hv_switch);

  // Relay and lamps registered so every output leaves a flop, no glitches on the relay
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_relay <= 1'b0;
      o_lamp <= '0;
    end else begin
      o_relay <= relay_nxt;
      o_lamp.armed_lamp <= i_sw.arm;
      o_lamp.hv_lamp <= i_sw.gun_hv_switch;
      o_lamp.charge_lamp <= i_sw.arm && !relay_nxt;
      o_lamp.discharge_lamp <= relay_nxt;
      o_lamp.green_lamp <= (blink_r != CNT_ZERO);
    end
  end

  // Green blink stretcher: retriggered by each pulse start so it is visible
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      blink_r <= CNT_ZERO;
    end else if (entering(state_r, state_nxt, DPS_PULSE)) begin
      blink_r <= CNT_W'(BLINK_CYC);
    end else if (blink_r != CNT_ZERO) begin
      blink_r <= blink_r - CNT_ONE;
    end
  end

  // Readout digit and its blanking
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_readout <= COUNT_ZERO;
      o_readout_on <= 1'b0;
    end else begin
      o_readout <= (!run || start) ? COUNT_ZERO : count_r;
      o_readout_on <= !i_sw.free_run;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  // Stretch counters of the relay output for the width and gap checks; they
  // saturate so a relay left open for hours cannot wrap into a false short gap
  logic [CNT_W-1:0] chk_hi_r;
  logic [CNT_W-1:0] chk_lo_r;

  // Cycles the relay has been closed in the current stretch
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      chk_hi_r <= CNT_ZERO;
    end else if (!o_relay) begin
      chk_hi_r <= CNT_ZERO;
    end else if (chk_hi_r != '1) begin
      chk_hi_r <= chk_hi_r + CNT_ONE;
    end
  end

  // Cycles the relay has been open in the current stretch
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      chk_lo_r <= CNT_ZERO;
    end else if (o_relay) begin
      chk_lo_r <= CNT_ZERO;
    end else if (chk_lo_r != '1) begin
      chk_lo_r <= chk_lo_r + CNT_ONE;
    end
  end

  a_zero_inhibit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_sw.count_sel == COUNT_ZERO && !i_sw.air_gap_mode) |=> state_r == DPS_IDLE)
    else $error("pulse sequence running with zero count");
  a_release_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !run |=> (count_r == COUNT_ZERO && state_r == DPS_IDLE))
    else $error("counter not cleared on release");
  a_burst_limit: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == DPS_DONE && $past(state_r) == DPS_PULSE) |-> count_r == $past(i_sw.count_sel))
    else $error("burst ended at wrong count");
  a_arm_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_sw.arm |=> !o_relay)
    else $error("relay closed while disarmed");
  a_hv_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_sw.gun_hv_switch |=> !o_relay)
    else $error("relay closed with gun high voltage off");
  a_first_dwell: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == DPS_IDLE && state_nxt == DPS_DWELL) |=> !o_relay [*2])
    else $error("pulse without preceding dwell");
  a_readout_blank: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_sw.free_run |=> !o_readout_on)
    else $error("readout lit in continuous mode");
  a_air_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_sw.air_gap_mode && run && i_sw.arm && i_sw.gun_hv_switch) |=> o_relay)
    else $error("air mode relay not held");
  a_restart: assert property (@(posedge i_core_clk) disable iff (i_rst)
    start |=> count_r == COUNT_ZERO)
    else $error("sequence not restarted");
  a_lamp_pair: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(o_lamp.charge_lamp && o_lamp.discharge_lamp))
    else $error("charge and discharge lamps both lit");

  // Timing and sequence-shape checks; width and gap checks use the helper counters
  a_pulse_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == DPS_PULSE && tmr_r == CNT_ZERO) |-> chk_hi_r == CNT_W'(PULSE_CYC - 1))
    else $error("relay pulse has wrong width");
  a_dwell_gap: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ($rose(o_relay) && !$past(i_sw.air_gap_mode)) |-> chk_lo_r >= CNT_W'(DWELL_BASE))
    else $error("relay pulse came before a full dwell");
  a_green_blink: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ($rose(o_relay) && !$past(i_sw.air_gap_mode)) |=> o_lamp.green_lamp)
    else $error("green lamp missed a pulse");
  a_done_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == DPS_DONE && go) |=> (state_r == DPS_DONE && !o_relay && o_readout == $past(count_r)))
    else $error("finished burst did not hold");
  a_single_shot: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == DPS_PULSE && tmr_r == CNT_ZERO && go && !start && !i_sw.free_run && i_sw.count_sel == COUNT_ONE)
    |=> state_r == DPS_DONE)
    else $error("single shot fired more than once");
  a_readout_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !run |=> o_readout == COUNT_ZERO)
    else $error("readout not cleared on release");

  c_burst_done: cover property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == DPS_PULSE ##1 state_r == DPS_DONE);
  c_single_shot: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_sw.count_sel == COUNT_ONE && state_r == DPS_DONE);
  c_free_run_two: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_sw.free_run && count_r == 4'h2);
  c_air_hold: cover property (@(posedge i_core_clk) disable iff (i_rst)
    i_sw.air_gap_mode && o_relay);
  c_retrigger: cover property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == DPS_DWELL && !run) ##1 start);

endmodule

// [dv/dps_relay_model.sv]
/*
  Relay side of the sequencer: counts relay closures and records how long
  the last one lasted. Assumes it sees the relay drive on the core clock.
*/
module dps_relay_model (
  input wire logic i_core_clk,
  input wire logic i_relay,
  input wire logic i_clear,
  output int o_pulses,
  output int o_width
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_len = 0;
  int pulses_q = 0;
  int width_q = 0;

  assign o_pulses = pulses_q;
  assign o_width = width_q;

  // ==========================================================
  // Closure counting
  // ==========================================================
  // A closure counts when it ends, so a held air-mode relay does not count until it opens
  always @(posedge i_core_clk) begin
    if (i_clear) begin
      pulses_q <= 0;
      run_len <= 0;
    end else if (i_relay === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      pulses_q <= pulses_q + 1;
      width_q <= run_len;
      run_len <= 0;
    end
  end
endmodule

// [dv/tb.sv]
/*
  Self-checking bench for the pulse sequencer with short counts.
  Assumes the relay model on the relay output and a 10 MHz clock.
*/
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %0t value mismatch", $time); end end
module tb
  import dps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, relay, rd_on, mclr;
  logic [3:0] rd;
  dps_sw_t sw;
  dps_panel_t panel;
  dps_lamp_t lamp;
  int n_errors = 0, n_tests = 0, pulses, width, lat;

  dps_sequencer #(.PULSE_CYC(5), .BLINK_CYC(8), .DWELL_BASE(20), .DWELL_STEP(2)) DUT (
    .i_core_clk(clk), .i_rst(rst), .i_sw(sw), .i_panel(panel),
    .o_relay(relay), .o_readout(rd), .o_readout_on(rd_on), .o_lamp(lamp));
  dps_relay_model u_relay (.i_core_clk(clk), .i_relay(relay), .i_clear(mclr),
    .o_pulses(pulses), .o_width(width));

  // ==========================================================
  // Clock, watchdog and helpers
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run needs about 1600 cycles; almost four times that means a hang
  initial begin
    #(6000 * 100);
    n_errors++;
    stop_test();
  end
  task automatic stop_test();
    $display("Tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Drop every run source while clearing the relay model for three cycles
  task automatic idle();
    sw.gun_trigger = 1'b0;
    sw.gun_auto = 1'b0;
    panel = DPS_PANEL_OFF;
    mclr = 1'b1;
    tick(3);
    mclr = 1'b0;
  endtask
  task automatic wait_rise();
    lat = 0;
    while (relay !== 1'b1 && lat < 300) begin
      tick(1);
      lat++;
    end
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    rst = 1'b1;
    mclr = 1'b0;
    sw = '0;
    panel = DPS_PANEL_OFF;
    tick(10);
    rst = 1'b0;
    tick(1);
    `CHK(relay, 1'b0)
    `CHK(lamp, 5'h00)
    sw.arm = 1'b1;
    sw.gun_hv_switch = 1'b1;
    sw.count_sel = 4'h3;
    tick(2);
    `CHK(lamp.armed_lamp, 1'b1)
    `CHK(lamp.hv_lamp, 1'b1)
    `CHK(lamp.charge_lamp, 1'b1)
    // Burst of three at the shortest dwell
    sw.gun_trigger = 1'b1;
    wait_rise();
    `CHK(lat inside {[20:24]}, 1'b1)
    tick(1);
    `CHK(lamp.discharge_lamp, 1'b1)
    `CHK(lamp.charge_lamp, 1'b0)
    `CHK(lamp.green_lamp, 1'b1)
    tick(150);
    `CHK(pulses, 3)
    `CHK(width, 5)
    `CHK(rd, 4'h3)
    `CHK(rd_on, 1'b1)
    `CHK(lamp.green_lamp, 1'b0)
    sw.gun_trigger = 1'b0;
    tick(2);
    `CHK(rd, 4'h0)
    // Retrigger in mid-burst restarts from zero
    idle();
    sw.count_sel = 4'h9;
    sw.gun_trigger = 1'b1;
    tick(60);
    sw.gun_trigger = 1'b0;
    tick(1);
    sw.gun_trigger = 1'b1;
    wait_rise();
    `CHK(lat inside {[20:24]}, 1'b1)
    tick(8);
    `CHK(rd, 4'h1)
    // Single shot from each run source
    for (int s = 0; s < 4; s++) begin
      idle();
      sw.count_sel = 4'h1;
      sw.gun_trigger = (s == 0);
      sw.gun_auto = (s == 1);
      panel = (s == 2) ? DPS_PANEL_AUTO : (s == 3) ? DPS_PANEL_MANUAL : DPS_PANEL_OFF;
      tick(120);
      `CHK(pulses, 1)
    end
    idle();
    `CHK(rd, 4'h0)
    // Zero count inhibits both modes
    for (int f = 0; f < 2; f++) begin
      idle();
      sw.count_sel = 4'h0;
      sw.free_run = f[0];
      sw.gun_trigger = 1'b1;
      tick(100);
      `CHK(pulses, 0)
    end
    // Continuous mode runs past the selected count
    idle();
    sw.count_sel = 4'h2;
    sw.gun_auto = 1'b1;
    tick(220);
    `CHK(pulses >= 5, 1'b1)
    `CHK(rd_on, 1'b0)
    // Longer dwell code
    idle();
    sw.free_run = 1'b0;
    sw.interval_sel = 8'h08;
    sw.gun_trigger = 1'b1;
    wait_rise();
    `CHK(lat inside {[36:40]}, 1'b1)
    // Interlocks: arm off, then gun high voltage off
    for (int k = 0; k < 2; k++) begin
      idle();
      sw.arm = k[0];
      sw.gun_hv_switch = ~k[0];
      sw.gun_trigger = 1'b1;
      tick(100);
      `CHK(pulses, 0)
    end
    // Air mode holds the relay for as long as the trigger is held
    idle();
    sw.gun_hv_switch = 1'b1;
    sw.air_gap_mode = 1'b1;
    sw.gun_trigger = 1'b1;
    tick(100);
    `CHK(relay, 1'b1)
    `CHK(pulses, 0)
    sw.gun_trigger = 1'b0;
    tick(3);
    `CHK(relay, 1'b0)
    stop_test();
  end
endmodule
